/* File: rtl/modctl.sv */
// modulation control: sweep, keying and burst sequencing behind an axi-lite slave
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module modctl
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // external ttl inputs
   input wire logic ext_trig,
   input wire logic ext_gate,
   input wire logic ext_fsk,
   // carrier datapath steering
   input wire logic carrier_wrap,
   output modctl_pkg::fm_cmd_t fm_cmd_q,
   output logic addr_run_q,
   output logic [modctl_pkg::WAW-1:0] addr_load_q,
   output logic addr_load_en_q,
   output logic dac_zero_q,
   output logic am_half_q,
   output logic busy_q
);
   modctl_pkg::ctrl_t ctrl_q;
   logic [31:0] start_q, stop_q, hop_q, rate_q, phase_q;
   logic [15:0] bcnt_q;
   logic [12:0] mlen_q, wlen_q;
   logic [modctl_pkg::MAW-1:0] mwaddr_q;
   logic [modctl_pkg::MAW-1:0] mod_mem [0:(1<<modctl_pkg::MAW)-1];
   logic swp_dirty_q, sw_trig_q;
   // bus write channel state
   logic [7:0] awa_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wd_q;
   logic wr_go;
   assign wr_go = aw_have_q && w_have_q && !s_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= modctl_pkg::RESP_OK;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            awa_q <= s_awaddr;
            aw_have_q <= 1'b1;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready)
         begin
            wd_q <= s_wdata;
            w_have_q <= 1'b1;
            s_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (awa_q > modctl_pkg::A_WLEN || awa_q[1:0] != 2'h0)
               ? modctl_pkg::RESP_ERR : modctl_pkg::RESP_OK;
         end
         if (s_bvalid && s_bready)
         begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end
   // register writes; byte strobes ignored, full words only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= modctl_pkg::CTRL_RST;
         start_q <= 32'h0000_0000;
         stop_q <= 32'h0000_0000;
         hop_q <= 32'h0000_0000;
         rate_q <= modctl_pkg::RATE_RST;
         bcnt_q <= modctl_pkg::BCNT_RST;
         phase_q <= 32'h0000_0000;
         mlen_q <= modctl_pkg::MLEN_RST;
         wlen_q <= modctl_pkg::WLEN_RST;
         mwaddr_q <= '0;
         sw_trig_q <= 1'b0;
      end
      else
      begin
         sw_trig_q <= 1'b0;
         if (wr_go)
            case (awa_q)
               modctl_pkg::A_CTRL: ctrl_q <= wd_q;
               modctl_pkg::A_START: start_q <= wd_q;
               modctl_pkg::A_STOP: stop_q <= wd_q;
               modctl_pkg::A_HOP: hop_q <= wd_q;
               modctl_pkg::A_RATE: rate_q <= wd_q;
               modctl_pkg::A_BCNT: bcnt_q <= wd_q[15:0];
               modctl_pkg::A_PHASE: phase_q <= wd_q;
               // length clamped to the legal table size
               modctl_pkg::A_MLEN: mlen_q <=
                  (wd_q[12:0] < modctl_pkg::MOD_MIN_LEN) ?
                  modctl_pkg::MOD_MIN_LEN :
                  (wd_q[12:0] > modctl_pkg::MOD_MAX_LEN) ?
                  modctl_pkg::MOD_MAX_LEN : wd_q[12:0];
               modctl_pkg::A_MDATA: mwaddr_q <= mwaddr_q + 1'b1;
               modctl_pkg::A_TRIG: sw_trig_q <= wd_q[0];
               modctl_pkg::A_WLEN: wlen_q <= wd_q[12:0];
               default: ;
            endcase
         if (wr_go && awa_q == modctl_pkg::A_MLEN)
            mwaddr_q <= '0;
      end
   end
   // modulation table written by software after each recompute
   always_ff @(posedge aclk)
   begin
      if (wr_go && awa_q == modctl_pkg::A_MDATA)
         mod_mem[mwaddr_q] <= wd_q[modctl_pkg::MAW-1:0];
   end
   // a change of sweep settings stalls sweeps until the table is reloaded
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         swp_dirty_q <= 1'b1;
      else if (wr_go && (awa_q == modctl_pkg::A_START ||
         awa_q == modctl_pkg::A_STOP || awa_q == modctl_pkg::A_RATE ||
         awa_q == modctl_pkg::A_CTRL))
         swp_dirty_q <= 1'b1;
      else if (wr_go && awa_q == modctl_pkg::A_MDATA &&
         {1'b0, mwaddr_q} == mlen_q - 13'h0001)
         swp_dirty_q <= 1'b0;
   end
   // two-flop synchronisers on the ttl inputs
   logic [2:0] s1_q, s2_q, s3_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end
      else
      begin
         s1_q <= {ext_trig, ext_gate, ext_fsk};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic trig_rise;
   assign trig_rise = s2_q[2] && !s3_q[2];
   // internal rate generator, shared by keying and burst pacing
   logic [31:0] rcnt_q;
   logic rate_tick, fsk_sq_q;
   assign rate_tick = (rcnt_q == 32'h0000_0000);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rcnt_q <= modctl_pkg::RATE_RST;
         fsk_sq_q <= 1'b0;
      end
      else if (ctrl_q.mode == modctl_pkg::MODE_FSK && ctrl_q.fsk_ext)
      begin
         rcnt_q <= rate_q;
         fsk_sq_q <= 1'b0;
      end
      else
      begin
         rcnt_q <= rate_tick ? rate_q : rcnt_q - 32'h0000_0001;
         if (rate_tick)
            fsk_sq_q <= !fsk_sq_q;
      end
   end
   // trigger source selection
   logic trig_any;
   always_comb
   begin
      if (ctrl_q.mode == modctl_pkg::MODE_BURST_TRIG && !ctrl_q.trig_ext)
         trig_any = rate_tick;
      else if (ctrl_q.trig_ext)
         trig_any = trig_rise;
      else
         trig_any = sw_trig_q;
   end
   // sweep and burst sequencer
   modctl_pkg::run_t run_q;
   logic [12:0] midx_q;
   logic [31:0] mdiv_q;
   logic [15:0] cyc_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_q <= modctl_pkg::RUN_IDLE;
         midx_q <= 13'h0000;
         mdiv_q <= 32'h0000_0000;
         cyc_q <= 16'h0000;
      end
      else
         case (run_q)
            modctl_pkg::RUN_IDLE:
               if (trig_any && ctrl_q.trig_en)
               begin
                  midx_q <= 13'h0000;
                  mdiv_q <= rate_q;
                  cyc_q <= bcnt_q;
                  if (ctrl_q.mode == modctl_pkg::MODE_SWEEP && !swp_dirty_q)
                     run_q <= modctl_pkg::RUN_ACTIVE;
                  else if (ctrl_q.mode == modctl_pkg::MODE_BURST_TRIG)
                     run_q <= modctl_pkg::RUN_LOAD;
               end
            modctl_pkg::RUN_LOAD:
               run_q <= modctl_pkg::RUN_ACTIVE;
            modctl_pkg::RUN_ACTIVE:
               // further triggers fall through unused here
               if (ctrl_q.mode == modctl_pkg::MODE_SWEEP)
               begin
                  // sweep time divides one table pass into equal steps
                  if (mdiv_q == 32'h0000_0000)
                  begin
                     mdiv_q <= rate_q;
                     if (midx_q == mlen_q - 13'h0001)
                        run_q <= modctl_pkg::RUN_IDLE;
                     else
                        midx_q <= midx_q + 13'h0001;
                  end
                  else
                     mdiv_q <= mdiv_q - 32'h0000_0001;
               end
               else if (ctrl_q.mode == modctl_pkg::MODE_BURST_TRIG)
               begin
                  if (carrier_wrap)
                  begin
                     if (cyc_q <= 16'h0001)
                        run_q <= modctl_pkg::RUN_IDLE;
                     else
                        cyc_q <= cyc_q - 16'h0001;
                  end
               end
               else
                  run_q <= modctl_pkg::RUN_IDLE;
            default:
               run_q <= modctl_pkg::RUN_IDLE;
         endcase
   end
   // frequency command: sweep centre and deviation, keying hop
   logic [32:0] sum;
   logic [32:0] dif;
   logic up;
   assign up = stop_q > start_q;
   assign sum = {1'b0, start_q} + {1'b0, stop_q};
   assign dif = up ? {1'b0, stop_q} - {1'b0, start_q}
      : {1'b0, start_q} - {1'b0, stop_q};
   logic hop_sel;
   assign hop_sel = ctrl_q.fsk_ext ? s2_q[0] : fsk_sq_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fm_cmd_q <= '0;
      else if (ctrl_q.mode == modctl_pkg::MODE_SWEEP)
      begin
         fm_cmd_q.center <= sum[32:1];
         fm_cmd_q.deviation <= dif[32:1];
         // table holds ramp or exponential, signed by direction
         fm_cmd_q.mod_sample <= (run_q == modctl_pkg::RUN_ACTIVE) ?
            mod_mem[midx_q[modctl_pkg::MAW-1:0]] : '0;
      end
      else if (ctrl_q.mode == modctl_pkg::MODE_FSK)
      begin
         fm_cmd_q.center <= start_q;
         fm_cmd_q.deviation <= hop_q - start_q;
         fm_cmd_q.mod_sample <= hop_sel ? {{(modctl_pkg::MAW-1){1'b0}},
            1'b1} : '0;
      end
      else
      begin
         fm_cmd_q.center <= start_q;
         fm_cmd_q.deviation <= 32'h0000_0000;
         fm_cmd_q.mod_sample <= '0;
      end
   end
   // waveform address control, gate and amplitude outputs
   logic [43:0] ph_prod;
   assign ph_prod = {12'h000, phase_q} * {31'h0000_0000, wlen_q};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_run_q <= 1'b1;
         addr_load_q <= '0;
         addr_load_en_q <= 1'b0;
         dac_zero_q <= 1'b0;
         am_half_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         // phase is a 32-bit turn fraction; zero is table entry zero
         addr_load_q <= ph_prod[43:32];
         addr_load_en_q <= ctrl_q.mode == modctl_pkg::MODE_BURST_TRIG &&
            run_q != modctl_pkg::RUN_ACTIVE;
         addr_run_q <= ctrl_q.mode != modctl_pkg::MODE_BURST_TRIG ||
            run_q == modctl_pkg::RUN_ACTIVE;
         // gate forces the converter input only; offset path is separate
         dac_zero_q <= ctrl_q.mode == modctl_pkg::MODE_BURST_GATE &&
            !s2_q[1];
         am_half_q <= ctrl_q.am_en;
         busy_q <= run_q != modctl_pkg::RUN_IDLE;
      end
   end
   // read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= modctl_pkg::RESP_OK;
      end
      else if (s_arvalid && s_arready)
      begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rresp <= modctl_pkg::RESP_OK;
         case (s_araddr)
            modctl_pkg::A_CTRL: s_rdata <= {24'h000000, ctrl_q[7:0]};
            modctl_pkg::A_START: s_rdata <= start_q;
            modctl_pkg::A_STOP: s_rdata <= stop_q;
            modctl_pkg::A_HOP: s_rdata <= hop_q;
            modctl_pkg::A_RATE: s_rdata <= rate_q;
            modctl_pkg::A_BCNT: s_rdata <= {16'h0000, bcnt_q};
            modctl_pkg::A_PHASE: s_rdata <= phase_q;
            modctl_pkg::A_MLEN: s_rdata <= {19'h00000, mlen_q};
            modctl_pkg::A_MDATA: s_rdata <= {20'h00000, mwaddr_q};
            modctl_pkg::A_TRIG: s_rdata <= 32'h0000_0000;
            modctl_pkg::A_STAT: s_rdata <= {24'h000000, s2_q, swp_dirty_q,
               up, 1'b0, run_q};
            modctl_pkg::A_WLEN: s_rdata <= {19'h00000, wlen_q};
            default:
            begin
               s_rdata <= 32'h0000_0000;
               s_rresp <= modctl_pkg::RESP_ERR;
            end
         endcase
      end
      else if (s_rvalid && s_rready)
      begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end
endmodule : modctl

/* File: rtl/modctl_pkg.sv */
// package: register map, field layout, sizes and modes of the modulation control
// Functional notes
// - sweep steps phase-continuously from start to stop in 2048 to 4096 steps
// - ascending sweep when stop above start, descending when below
// - sweep mode picks linear ramp or exponential step spacing
// - sweep centre is half sum, deviation half difference of end frequencies
// - sweep time sets period of one modulating waveform cycle
// - in triggered sweep each accepted trigger runs exactly one sweep cycle
// - any sweep parameter change reloads modulation memory before taking effect; code only blocks new sweeps after start, stop, rate or control writes
// - keying switches output between carrier and hop, internal or external rate
// - external keying low selects carrier, high selects hop
// - external keying disables the internal keying rate source
// - internal keying rate sets the square modulation period
// - keying square spans zero to one; deviation is hop minus carrier
// - each burst trigger yields exactly the configured count of whole cycles
// - start phase zero is the first waveform memory sample
// - between bursts output holds the sample at the start phase
// - burst never alters the dc offset path
// - gated burst: high runs carrier, low forces converter input to zero
// - gate acts on converter output directly, without cycle alignment
// - burst count, rate and phase ignored in gated mode
// - address advance halts at last sample of final counted cycle
// - internal burst rate generator triggers each internally paced burst
// - external trigger alone starts bursts in external triggered mode
// - modulation memory holds 2048 to 4096 point waveforms
package modctl_pkg;
   localparam int FW = 32;
   localparam int MAW = 12;
   localparam int WAW = 12;
   localparam logic [12:0] MOD_MIN_LEN = 13'h0800;
   localparam logic [12:0] MOD_MAX_LEN = 13'h1000;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_START = 8'h04;
   localparam logic [7:0] A_STOP = 8'h08;
   localparam logic [7:0] A_HOP = 8'h0C;
   localparam logic [7:0] A_RATE = 8'h10;
   localparam logic [7:0] A_BCNT = 8'h14;
   localparam logic [7:0] A_PHASE = 8'h18;
   localparam logic [7:0] A_MLEN = 8'h1C;
   localparam logic [7:0] A_MDATA = 8'h20;
   localparam logic [7:0] A_TRIG = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   localparam logic [7:0] A_WLEN = 8'h2C;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [12:0] MLEN_RST = 13'h0800;
   localparam logic [12:0] WLEN_RST = 13'h1000;
   localparam logic [31:0] RATE_RST = 32'h0000_1000;
   localparam logic [15:0] BCNT_RST = 16'h0001;
   typedef enum logic [2:0] {MODE_OFF, MODE_SWEEP, MODE_FSK, MODE_BURST_TRIG,
      MODE_BURST_GATE} mode_t;
   // control word fields
   typedef struct packed {
      logic [23:0] rsvd;
      logic am_en;
      logic trig_ext;
      logic trig_en;
      logic fsk_ext;
      logic sweep_log;
      mode_t mode;
   } ctrl_t;
   // frequency command to the carrier synthesiser
   typedef struct packed {
      logic [FW-1:0] center;
      logic [FW-1:0] deviation;
      logic [MAW-1:0] mod_sample;
   } fm_cmd_t;
   typedef enum logic [1:0] {RUN_IDLE, RUN_LOAD, RUN_ACTIVE} run_t;
endpackage : modctl_pkg

/* File: dv/modctl_chk.sv */
// checker: bus handshake and burst sequencing assertions for modctl
`timescale 1ns/1ps
module modctl_chk
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshake
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic s_rready,
   // ttl and carrier steering
   input wire logic ext_gate,
   input wire logic carrier_wrap,
   input wire logic addr_run_q,
   input wire logic addr_load_en_q,
   input wire logic dac_zero_q,
   input wire logic busy_q
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // address and data taken together, then the answer follows
   sequence wr_take;
      s_awvalid && s_awready && s_wvalid && s_wready;
   endsequence
   sequence wr_answer;
      ##[1:2] s_bvalid;
   endsequence
   wr_resp_a: assert property (wr_take |-> wr_answer)
      else $error("write answer late");
   b_once_a: assert property (s_bvalid && s_bready |=> !s_bvalid)
      else $error("write answer held after handshake");
   wr_block_a: assert property (s_bvalid |-> !s_awready && !s_wready)
      else $error("write taken while answer pending");
   rd_resp_a: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   r_once_a: assert property (s_rvalid && s_rready |=> !s_rvalid)
      else $error("read answer held after handshake");
   rd_block_a: assert property (s_rvalid |-> !s_arready)
      else $error("read taken while answer pending");
   load_hold_a: assert property (addr_load_en_q |-> !addr_run_q)
      else $error("address runs while start phase is loaded");
   // two synchroniser flops plus the output register: the level is three deep
   gate_zero_a: assert property ($rose(dac_zero_q)
      |-> !$past(ext_gate, 3))
      else $error("converter zeroed with gate high");
   // wrap seen, sequencer idles, then the registered run level drops
   burst_stop_a: assert property ($fell(addr_run_q) && $past(busy_q)
      |-> $past(carrier_wrap, 2))
      else $error("burst halted away from a cycle end");
endmodule : modctl_chk

bind modctl modctl_chk u_chk
(
   .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
   .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rvalid, .s_rready,
   .ext_gate, .carrier_wrap, .addr_run_q, .addr_load_en_q, .dac_zero_q,
   .busy_q
);

/* File: dv/ttl_src.sv */
// partner: ttl trigger, gate and keying sources and a carrier wrap model
`timescale 1ns/1ps
module ttl_src
#(
   parameter int WRAP_PERIOD = 8
)
(
   // clock and carrier steering
   input wire logic aclk,
   input wire logic addr_run_q,
   // ttl lines and wrap pulse
   output logic ext_trig,
   output logic ext_gate,
   output logic ext_fsk,
   output logic carrier_wrap
);
   int cyc_q;
   int wraps;
   // idle levels: no trigger, gate open, carrier selected
   initial
   begin
      ext_trig = 1'b0;
      ext_gate = 1'b1;
      ext_fsk = 1'b0;
   end
   // a wrap pulse ends each carrier cycle; restart when addressing halts
   always_ff @(posedge aclk)
   begin
      carrier_wrap <= 1'b0;
      cyc_q <= 0;
      if (addr_run_q === 1'b1)
      begin
         cyc_q <= (cyc_q == WRAP_PERIOD - 1) ? 0 : cyc_q + 1;
         if (cyc_q == WRAP_PERIOD - 1)
         begin
            carrier_wrap <= 1'b1;
            wraps <= wraps + 1;
         end
      end
   end
   // held four cycles so the synchroniser cannot miss the edge
   task trig_pulse();
      @(posedge aclk);
      ext_trig <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_trig <= 1'b0;
   endtask : trig_pulse
   task set_gate(input logic v);
      @(posedge aclk);
      ext_gate <= v;
   endtask : set_gate
   task set_fsk(input logic v);
      @(posedge aclk);
      ext_fsk <= v;
   endtask : set_fsk
endmodule : ttl_src

/* File: dv/modctl_tb.sv */
// testbench: register access, keying, gating, burst and sweep sequences
`timescale 1ns/1ps
module modctl_tb;
   logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
   logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   logic ext_trig, ext_gate, ext_fsk, carrier_wrap, addr_run_q;
   logic addr_load_en_q, dac_zero_q, am_half_q, busy_q;
   logic [11:0] addr_load_q;
   modctl_pkg::fm_cmd_t fm_cmd_q;
   int n_fail = 0;
   int cmp_count = 0;
   modctl u_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
      .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .ext_trig, .ext_gate, .ext_fsk, .carrier_wrap,
      .fm_cmd_q, .addr_run_q, .addr_load_q, .addr_load_en_q, .dac_zero_q,
      .am_half_q, .busy_q);
   ttl_src u_src (.aclk, .addr_run_q, .ext_trig, .ext_gate, .ext_fsk,
      .carrier_wrap);
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bready rises with the request and is held until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      logic ta, tw, tb;
      logic [1:0] rs;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 50 && !tb; n++)
      begin
         @(negedge aclk);
         ta = s_awvalid & s_awready;
         tw = s_wvalid & s_wready;
         tb = s_bvalid;
         rs = s_bresp;
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tb) s_bready <= 1'b0;
      end
      chk({31'h0, tb}, 32'h1);
      chk({30'h0, rs}, {30'h0, er});
      if (!tb)
         final_report();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      int n;
      logic ta, tr;
      logic [31:0] dv;
      logic [1:0] rs;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 50 && !tr; n++)
      begin
         @(negedge aclk);
         ta = s_arvalid & s_arready;
         tr = s_rvalid;
         dv = s_rdata;
         rs = s_rresp;
         @(posedge aclk);
         if (ta) s_arvalid <= 1'b0;
         if (tr) s_rready <= 1'b0;
      end
      chk(dv, ed);
      chk({30'h0, rs}, {30'h0, er});
      if (!tr)
         final_report();
   endtask : rd
   // bounded wait on the sequencer; running out ends the run
   task automatic wait_busy(input logic v, input int lim);
      int n;
      @(negedge aclk);
      for (n = 0; n < lim && busy_q !== v; n++)
         @(negedge aclk);
      chk({31'h0, busy_q}, {31'h0, v});
      if (busy_q !== v)
         final_report();
   endtask : wait_busy
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial
   begin
      repeat (100000) @(posedge aclk);
      n_fail++;
      final_report();
   end
   // main sequence
   initial
   begin
      logic [7:0] ra [5];
      logic [31:0] rv [5];
      int i, tg, w0;
      logic hp;
      time t0;
      ra = '{modctl_pkg::A_CTRL, modctl_pkg::A_RATE, modctl_pkg::A_BCNT,
         modctl_pkg::A_MLEN, modctl_pkg::A_WLEN};
      rv = '{modctl_pkg::CTRL_RST, modctl_pkg::RATE_RST,
         32'(modctl_pkg::BCNT_RST), 32'(modctl_pkg::MLEN_RST),
         32'(modctl_pkg::WLEN_RST)};
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata} = '0;
      s_wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 5; i++)
         rd(ra[i], rv[i], modctl_pkg::RESP_OK);
      rd(8'h30, 32'h0, modctl_pkg::RESP_ERR);
      wr(8'h34, 32'hFF, modctl_pkg::RESP_ERR);
      wr(8'h05, 32'hFF, modctl_pkg::RESP_ERR);
      wr(modctl_pkg::A_CTRL, 32'h80, modctl_pkg::RESP_OK);
      repeat (2) @(negedge aclk);
      chk({31'h0, am_half_q}, 32'h1);
      // keying, external level first with a fast internal rate behind it
      wr(modctl_pkg::A_RATE, 32'h10, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_START, 32'h1000, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_HOP, 32'h400, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_CTRL, 32'h12, modctl_pkg::RESP_OK);
      repeat (6) @(negedge aclk);
      chk(fm_cmd_q.center, 32'h1000);
      chk(fm_cmd_q.deviation, 32'hFFFF_F400);
      chk(32'(fm_cmd_q.mod_sample), 32'h0);
      u_src.set_fsk(1'b1);
      repeat (5) @(negedge aclk);
      for (i = 0; i < 40; i++)
         @(negedge aclk) chk(32'(fm_cmd_q.mod_sample != 0), 32'h1);
      u_src.set_fsk(1'b0);
      wr(modctl_pkg::A_CTRL, 32'h02, modctl_pkg::RESP_OK);
      tg = 0;
      hp = 1'b0;
      for (i = 0; i < 64; i++)
      begin
         @(negedge aclk);
         if ((fm_cmd_q.mod_sample != 0) != hp) tg++;
         hp = (fm_cmd_q.mod_sample != 0);
      end
      chk(32'(tg >= 3), 32'h1);
      // gated burst: level alone rules, count and rate are ignored
      wr(modctl_pkg::A_CTRL, 32'h04, modctl_pkg::RESP_OK);
      u_src.set_gate(1'b0);
      repeat (5) @(negedge aclk);
      chk({31'h0, dac_zero_q}, 32'h1);
      u_src.set_gate(1'b1);
      repeat (5) @(negedge aclk);
      chk({31'h0, dac_zero_q}, 32'h0);
      for (i = 0; i < 40; i++)
         @(negedge aclk) chk({31'h0, addr_run_q}, 32'h1);
      wr(modctl_pkg::A_CTRL, 32'h0, modctl_pkg::RESP_OK);
      // externally triggered burst of two cycles from a quarter turn
      wr(modctl_pkg::A_BCNT, 32'h2, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_PHASE, 32'h4000_0000, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_CTRL, 32'h63, modctl_pkg::RESP_OK);
      repeat (4) @(negedge aclk);
      chk({31'h0, addr_run_q}, 32'h0);
      chk({31'h0, addr_load_en_q}, 32'h1);
      chk(32'(addr_load_q), 32'h400);
      w0 = u_src.wraps;
      u_src.trig_pulse();
      wait_busy(1'b1, 20);
      u_src.trig_pulse();
      wait_busy(1'b0, 200);
      repeat (20) @(negedge aclk);
      chk(32'(u_src.wraps - w0), 32'h2);
      wr(modctl_pkg::A_TRIG, 32'h1, modctl_pkg::RESP_OK);
      repeat (10) @(negedge aclk);
      chk({31'h0, busy_q}, 32'h0);
      // internally paced bursts repeat on their own
      wr(modctl_pkg::A_RATE, 32'h40, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_CTRL, 32'h23, modctl_pkg::RESP_OK);
      wait_busy(1'b1, 300);
      wait_busy(1'b0, 300);
      wait_busy(1'b1, 300);
      wr(modctl_pkg::A_CTRL, 32'h0, modctl_pkg::RESP_OK);
      // triggered sweep after the table is fully rewritten
      wr(modctl_pkg::A_CTRL, 32'h21, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_RATE, 32'h1, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_STOP, 32'h3000, modctl_pkg::RESP_OK);
      wr(modctl_pkg::A_MLEN, 32'h800, modctl_pkg::RESP_OK);
      // a trigger before the table is reloaded must not start a sweep
      wr(modctl_pkg::A_TRIG, 32'h1, modctl_pkg::RESP_OK);
      repeat (4) @(negedge aclk);
      chk({31'h0, busy_q}, 32'h0);
      for (i = 0; i < 2048; i++)
         wr(modctl_pkg::A_MDATA, 32'(i), modctl_pkg::RESP_OK);
      repeat (4) @(negedge aclk);
      chk(fm_cmd_q.center, 32'h2000);
      chk(fm_cmd_q.deviation, 32'h1000);
      wr(modctl_pkg::A_TRIG, 32'h1, modctl_pkg::RESP_OK);
      wait_busy(1'b1, 50);
      t0 = $time;
      wait_busy(1'b0, 20000);
      // one table pass: 2048 points, each held rate plus one cycles
      chk(32'(($time - t0) / 100), 32'h0000_1000);
      repeat (20) @(negedge aclk);
      chk({31'h0, busy_q}, 32'h0);
      final_report();
   end
endmodule : modctl_tb
